/* gast_map.svh */
`ifndef GAST_MAP_SVH
`define GAST_MAP_SVH

// Register byte addresses
`define GAST_ADDR_STATUS 8'h00
`define GAST_ADDR_MODE 8'h04
`define GAST_ADDR_OWN 8'h08
`define GAST_ADDR_CMD 8'h0C
`define GAST_ADDR_IRQ_STAT 8'h10
`define GAST_ADDR_IRQ_EN 8'h14
`define GAST_ADDR_IRQ_CLR 8'h18

// address_status fields
`define GAST_ST_LSN_PRI 4
`define GAST_ST_TLK_PRI 3
`define GAST_ST_LSN_ACT 2
`define GAST_ST_TLK_ACT 1
`define GAST_ST_MAJ_MIN 0

// address_mode_config fields
`define GAST_MODE_LO 0
`define GAST_MODE_HI 1
`define GAST_MODE_LON 2
`define GAST_MODE_TON 3

// Own address fields
`define GAST_OWN_MAJ_LO 0
`define GAST_OWN_MIN_LO 8
`define GAST_OWN_W 5

// Command register bits
`define GAST_CMD_PON 0
`define GAST_CMD_LUN 1
`define GAST_CMD_LUL 2
`define GAST_CMD_LUT 3

// Interrupt bits
`define GAST_IRQ_LSN 0
`define GAST_IRQ_TLK 1
`define GAST_IRQ_W 2

// Bus command bytes
`define GAST_LAG_BASE 8'h20
`define GAST_TAG_BASE 8'h40
`define GAST_UNL 8'h3F

// Reset values
`define GAST_MODE_RST 4'h0
`define GAST_OWN_RST 5'h00

`endif

/* gast_pkg.sv */
package gast_pkg;

    typedef struct packed {
        logic listener_primary_addressed;
        logic talker_primary_addressed;
        logic listener_active;
        logic talker_active;
        logic major_minor_indicator;
    } gast_addr_t;

    typedef enum logic [1:0] {
        GAST_SINGLE,
        GAST_EXT_SINGLE,
        GAST_DUAL,
        GAST_EXT_DUAL
    } gast_amode_t;

endpackage

/* gast_tracker.sv */
// Summary of operation
// - Own listen address sets listener primary addressed
// - Other primary command or pon clears it
// - Own talk address sets talker primary addressed
// - Other primary command or pon clears it
// - Listener active bit reflects addressed listener
// - Listen-only bit makes device listen unaddressed
// - Becoming talker drops listener addressing
// - UNL, IFC, pon, lul, and lun while ctrl_active is high clear listener
// - Talker active bit reflects talker or poll
// - Talk-only bit makes device talk unaddressed
// - Becoming listener drops talker addressing
// - Other talk address, IFC, pon, lut clear
// - Minor address sets major-minor indicator
// - Major address clears major-minor indicator
// - Power-on clears major-minor indicator
// - Only one function active unless listen-only or talk-only forces one; indicator selects
// - Indicator zero unless dual addressing mode

`include "gast_map.svh"

module gast_tracker
    import gast_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Bus side events
    input wire logic cmd_accept,
    input wire logic [7:0] cmd_byte,
    input wire logic ifc,
    input wire logic ctrl_active,
    input wire logic serial_poll_active,
    // Status out
    output logic listener_active,
    output logic talker_active,
    output logic irq
);

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        // Host-visible address status
        gast_addr_t st;
        logic [3:0] mode;
        logic [4:0] own_maj;
        logic [4:0] own_min;
        logic [1:0] irq_stat;
        logic [1:0] irq_en;
        // Register bus bookkeeping
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } gast_state_t;

    gast_state_t s_q;
    gast_state_t s_d;

    // ************************************************
    // Address decode of accepted command bytes
    // ************************************************
    logic dual;
    logic pcg;
    logic is_lag;
    logic is_tag;
    logic mla_maj;
    logic mla_min;
    logic mta_maj;
    logic mta_min;
    logic mla;
    logic mta;
    logic unl;
    logic ota;

    always_comb begin
        // Only the dual modes give the minor address a meaning
        dual = (gast_amode_t'(s_q.mode[`GAST_MODE_HI:`GAST_MODE_LO]) == GAST_DUAL)
            || (gast_amode_t'(s_q.mode[`GAST_MODE_HI:`GAST_MODE_LO]) == GAST_EXT_DUAL);
        // Primary command group: everything below the secondary range
        pcg = cmd_accept && (cmd_byte[6:5] != 2'h3) && !cmd_byte[7];
        is_lag = cmd_byte[7:5] == 3'(`GAST_LAG_BASE >> 5);
        is_tag = cmd_byte[7:5] == 3'(`GAST_TAG_BASE >> 5);
        mla_maj = pcg && is_lag && (cmd_byte[4:0] == s_q.own_maj);
        mta_maj = pcg && is_tag && (cmd_byte[4:0] == s_q.own_maj);
        // Minor address only exists in dual primary modes
        mla_min = dual && pcg && is_lag && (cmd_byte[4:0] == s_q.own_min) && !mla_maj;
        mta_min = dual && pcg && is_tag && (cmd_byte[4:0] == s_q.own_min) && !mta_maj;
        mla = mla_maj || mla_min;
        mta = mta_maj || mta_min;
        unl = cmd_accept && (cmd_byte == `GAST_UNL);
        // Any talk-group byte that is not ours, untalk included
        ota = pcg && is_tag && !mta;
    end

    // ************************************************
    // Register bus decode
    // ************************************************
    logic aw_hs;
    logic w_hs;
    logic do_wr;
    logic do_rd;
    logic wr_known;
    logic rd_known;
    logic [31:0] wdat;
    logic [31:0] rd_val;
    logic [7:0] status_byte;
    logic wr_cmd;
    logic pon;
    logic lun;
    logic lul;
    logic lut;
    logic lsn_evt;
    logic tlk_evt;

    always_comb begin
        // Ready drops while a response waits: one write and one read in flight
        s_axi_awready = !s_q.aw_have && !s_q.bvalid;
        s_axi_wready = !s_q.w_have && !s_q.bvalid;
        s_axi_arready = !s_q.rvalid;
        aw_hs = s_axi_awvalid && s_axi_awready;
        w_hs = s_axi_wvalid && s_axi_wready;
        do_wr = s_q.aw_have && s_q.w_have;
        do_rd = s_axi_arvalid && s_axi_arready;
        wdat = s_q.w_data;
        // Commands are strobes that exist only in the write cycle
        wr_cmd = do_wr && (s_q.aw_addr == `GAST_ADDR_CMD) && s_q.w_strb[0];
        pon = wr_cmd && wdat[`GAST_CMD_PON];
        lun = wr_cmd && wdat[`GAST_CMD_LUN];
        lul = wr_cmd && wdat[`GAST_CMD_LUL];
        lut = wr_cmd && wdat[`GAST_CMD_LUT];
        // Unmapped offsets answer with a slave error and change nothing
        case (s_q.aw_addr)
            `GAST_ADDR_STATUS, `GAST_ADDR_MODE, `GAST_ADDR_OWN, `GAST_ADDR_CMD,
            `GAST_ADDR_IRQ_STAT, `GAST_ADDR_IRQ_EN, `GAST_ADDR_IRQ_CLR: begin
                wr_known = 1'b1;
            end
            default: begin
                wr_known = 1'b0;
            end
        endcase
        // Upper status bits belong to functions outside this block
        status_byte = 8'h00;
        status_byte[`GAST_ST_LSN_PRI] = s_q.st.listener_primary_addressed;
        status_byte[`GAST_ST_TLK_PRI] = s_q.st.talker_primary_addressed;
        status_byte[`GAST_ST_LSN_ACT] = s_q.st.listener_active;
        // Serial poll activity shows as talker too
        status_byte[`GAST_ST_TLK_ACT] = s_q.st.talker_active || serial_poll_active;
        status_byte[`GAST_ST_MAJ_MIN] = s_q.st.major_minor_indicator && dual;
        rd_known = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            `GAST_ADDR_STATUS: begin
                rd_val[7:0] = status_byte;
            end
            `GAST_ADDR_MODE: begin
                rd_val[3:0] = s_q.mode;
            end
            `GAST_ADDR_OWN: begin
                rd_val[`GAST_OWN_MAJ_LO +: `GAST_OWN_W] = s_q.own_maj;
                rd_val[`GAST_OWN_MIN_LO +: `GAST_OWN_W] = s_q.own_min;
            end
            `GAST_ADDR_IRQ_STAT: begin
                rd_val[1:0] = s_q.irq_stat;
            end
            `GAST_ADDR_IRQ_EN: begin
                rd_val[1:0] = s_q.irq_en;
            end
            `GAST_ADDR_CMD, `GAST_ADDR_IRQ_CLR: begin
                rd_val = 32'h0000_0000;
            end
            default: begin
                rd_known = 1'b0;
            end
        endcase
    end

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        s_d = s_q;

        // Capture write channels independently
        if (aw_hs) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (w_hs) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (do_wr) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = wr_known ? 2'h0 : 2'h2;
            if (s_q.aw_addr == `GAST_ADDR_MODE && s_q.w_strb[0]) begin
                s_d.mode = wdat[3:0];
            end
            if (s_q.aw_addr == `GAST_ADDR_OWN && s_q.w_strb[0]) begin
                s_d.own_maj = wdat[`GAST_OWN_MAJ_LO +: `GAST_OWN_W];
            end
            if (s_q.aw_addr == `GAST_ADDR_OWN && s_q.w_strb[1]) begin
                s_d.own_min = wdat[`GAST_OWN_MIN_LO +: `GAST_OWN_W];
            end
            if (s_q.aw_addr == `GAST_ADDR_IRQ_EN && s_q.w_strb[0]) begin
                s_d.irq_en = wdat[1:0];
            end
            if (s_q.aw_addr == `GAST_ADDR_IRQ_CLR && s_q.w_strb[0]) begin
                s_d.irq_stat = s_q.irq_stat & ~wdat[1:0];
            end
        end

        // Reads only sample state
        // Read data is latched at the address handshake so it cannot tear
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (do_rd) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_val;
            s_d.rresp = rd_known ? 2'h0 : 2'h2;
        end

        // Primary addressed flags
        // Unlisten is a primary command too, so it also clears these
        if (pcg && !mla) begin
            s_d.st.listener_primary_addressed = 1'b0;
        end
        if (mla) begin
            s_d.st.listener_primary_addressed = 1'b1;
        end
        if (pcg && !mta) begin
            s_d.st.talker_primary_addressed = 1'b0;
        end
        if (mta) begin
            s_d.st.talker_primary_addressed = 1'b1;
        end

        // Listener state
        if (unl || ifc || lul || (lun && ctrl_active)) begin
            s_d.st.listener_active = 1'b0;
        end
        if (mta) begin
            s_d.st.listener_active = 1'b0;
        end
        if (mla) begin
            s_d.st.listener_active = 1'b1;
        end

        // Talker state
        if (ota || ifc || lut) begin
            s_d.st.talker_active = 1'b0;
        end
        if (mla) begin
            s_d.st.talker_active = 1'b0;
        end
        if (mta) begin
            s_d.st.talker_active = 1'b1;
        end

        // Interface clear dominates a byte taken in the same cycle
        if (ifc) begin
            s_d.st.listener_active = 1'b0;
            s_d.st.talker_active = 1'b0;
        end

        // Programmed operation wins over bus unaddressing
        if (s_q.mode[`GAST_MODE_LON]) begin
            s_d.st.listener_active = 1'b1;
        end
        if (s_q.mode[`GAST_MODE_TON]) begin
            s_d.st.talker_active = 1'b1;
        end

        // Which address pair the flags describe
        if (mla_min || mta_min) begin
            s_d.st.major_minor_indicator = 1'b1;
        end
        if (mla_maj || mta_maj) begin
            s_d.st.major_minor_indicator = 1'b0;
        end
        // Outside the dual modes the indicator is forced to zero
        if (!dual) begin
            s_d.st.major_minor_indicator = 1'b0;
        end

        // Power-on local message
        if (pon) begin
            s_d.st = '0;
        end

        // Sticky events; a new event beats a same-cycle clear
        lsn_evt = (s_d.st.listener_active != s_q.st.listener_active)
            || (s_d.st.listener_primary_addressed != s_q.st.listener_primary_addressed);
        tlk_evt = (s_d.st.talker_active != s_q.st.talker_active)
            || (s_d.st.talker_primary_addressed != s_q.st.talker_primary_addressed);
        if (lsn_evt) begin
            s_d.irq_stat[`GAST_IRQ_LSN] = 1'b1;
        end
        if (tlk_evt) begin
            s_d.irq_stat[`GAST_IRQ_TLK] = 1'b1;
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    always_ff @(posedge sys_clk) begin
        // Reset is synchronous and loads constants only
        if (!resetn) begin
            s_q <= '0;
            s_q.mode <= `GAST_MODE_RST;
            s_q.own_maj <= `GAST_OWN_RST;
            s_q.own_min <= `GAST_OWN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    always_comb begin
        s_axi_bvalid = s_q.bvalid;
        s_axi_bresp = s_q.bresp;
        s_axi_rvalid = s_q.rvalid;
        s_axi_rdata = s_q.rdata;
        s_axi_rresp = s_q.rresp;
        // Serial poll is left off the pin; software sees it in the status word
        listener_active = s_q.st.listener_active;
        talker_active = s_q.st.talker_active;
        // Level interrupt: high while any enabled event bit is set
        irq = |(s_q.irq_stat & s_q.irq_en);
    end

endmodule

/* gast_tracker_chk.sv */
// ****
// Address status checker
// ****
module gast_tracker_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Bus events and status
    input wire logic cmd_accept,
    input wire logic [7:0] cmd_byte,
    input wire logic ifc,
    input wire logic listener_active,
    input wire logic talker_active
);
    timeunit 1ns;
    timeprecision 1ns;
    // Forcing bits shadowed from writes that offer both channels together
    logic [1:0] md_q;
    logic [1:0] md1_q;
    logic nf;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            md_q <= 2'h0;
            md1_q <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                && s_axi_awaddr == 8'h04) md_q <= s_axi_wdata[3:2];
            md1_q <= md_q;
        end
    end
    assign nf = (md_q == 2'h0) && (md1_q == 2'h0);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_unl_drop;
        cmd_accept && cmd_byte == 8'h3F && nf |=> !listener_active;
    endproperty
    a_unl_drop: assert property (p_unl_drop) else $error("listener kept");
    property p_ifc_clear;
        ifc && nf |=> !listener_active && !talker_active;
    endproperty
    a_ifc_clear: assert property (p_ifc_clear) else $error("ifc ignored");
    property p_tlk_excl;
        $rose(talker_active) && nf && $past(nf) |-> !listener_active;
    endproperty
    a_tlk_excl: assert property (p_tlk_excl) else $error("both addressed");
    property p_lsn_excl;
        $rose(listener_active) && nf && $past(nf) |-> !talker_active;
    endproperty
    a_lsn_excl: assert property (p_lsn_excl) else $error("both addressed");
    property p_lsn_cause;
        $rose(listener_active) && nf && $past(nf) |-> $past(cmd_accept)
            && $past(cmd_byte[7:5]) == 3'h1 && $past(cmd_byte) != 8'h3F;
    endproperty
    a_lsn_cause: assert property (p_lsn_cause) else $error("listen no cause");
    property p_tlk_cause;
        $rose(talker_active) && nf && $past(nf) |->
            $past(cmd_accept) && $past(cmd_byte[7:5]) == 3'h2;
    endproperty
    a_tlk_cause: assert property (p_tlk_cause) else $error("talk no cause");
    property p_tlk_fall;
        $fell(talker_active) |->
            $past(cmd_accept) || $past(ifc) || s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_tlk_fall: assert property (p_tlk_fall) else $error("talk lost");
    property p_lsn_fall;
        $fell(listener_active) |->
            $past(cmd_accept) || $past(ifc) || s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_lsn_fall: assert property (p_lsn_fall) else $error("listen lost");
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
    c_lsn: cover property ($rose(listener_active));
    c_tlk: cover property ($rose(talker_active));
    c_ifc: cover property (ifc ##1 !talker_active);
endmodule

bind gast_tracker gast_tracker_chk u_chk (.*);

/* gast_ctl_model.sv */
// ****
// Bus controller model
// ****
module gast_ctl_model (
    // Clock
    input wire logic sys_clk,
    // Command side
    output logic cmd_accept,
    output logic [7:0] cmd_byte,
    output logic ifc,
    output logic ctrl_active,
    output logic serial_poll_active
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cmd_accept = 1'b0;
        cmd_byte = 8'hFF;
        ifc = 1'b0;
        ctrl_active = 1'b0;
        serial_poll_active = 1'b0;
    end
    // Released data lines show the inverse so stale bytes never look valid
    task automatic send(input logic [7:0] b);
        @(posedge sys_clk);
        cmd_byte <= b;
        cmd_accept <= 1'b1;
        @(posedge sys_clk);
        cmd_accept <= 1'b0;
        cmd_byte <= ~b;
    endtask
    task automatic clr();
        @(posedge sys_clk);
        ifc <= 1'b1;
        @(posedge sys_clk);
        ifc <= 1'b0;
    endtask
    task automatic lvl(input logic c, input logic s);
        @(posedge sys_clk);
        ctrl_active <= c;
        serial_poll_active <= s;
    endtask
endmodule

/* gpib_address_status_tracker_test.sv */
// ****
// Testbench
// ****
module gpib_address_status_tracker_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, resetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr, cmd_byte;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic cmd_accept, ifc, ctrl_active, serial_poll_active;
    logic listener_active, talker_active, irq;
    logic [33:0] q[$];
    logic [33:0] nxt;
    int num_errors = 0;
    int cmp_count = 0;
    logic [7:0] b;
    gast_tracker uut (.*);
    gast_ctl_model ctl (.*);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [2:0] p;
        logic [1:0] er;
        p = 3'h7;
        er = (a > 8'h18 || a[1:0] != 2'h0) ? 2'h2 : 2'h0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= p;
        for (int n = 0; n < 50 && p != 3'h0; n++) begin
            @(negedge sys_clk);
            if (p[0] && s_axi_bvalid) chk(32'(s_axi_bresp), 32'(er));
            p = p & ~{s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge sys_clk);
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= p;
        end
        if (p != 3'h0) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [1:0] p;
        p = 2'h3;
        q.push_back({(a > 8'h18 || a[1:0] != 2'h0) ? 2'h2 : 2'h0, e});
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= p;
        for (int n = 0; n < 50 && p != 2'h0; n++) begin
            @(negedge sys_clk);
            p = p & ~{s_axi_arready, s_axi_rvalid};
            @(posedge sys_clk);
            {s_axi_arvalid, s_axi_rready} <= p;
        end
        if (p != 2'h0) begin
            num_errors++;
            tally_and_finish();
        end
    endtask
    // Send one command byte, then read status and the two status pins
    task automatic cs(input logic [7:0] c, input logic [7:0] e);
        ctl.send(c);
        @(negedge sys_clk);
        chk(32'(listener_active), 32'(e[2]));
        chk(32'(talker_active), 32'(e[1]));
        rd(8'h00, 32'(e));
    endtask
    always @(negedge sys_clk) begin
        if (resetn && s_axi_rvalid && s_axi_rready) begin
            if (q.size() == 0) begin
                chk(s_axi_rdata, 32'hFFFFFFFF);
            end else begin
                nxt = q.pop_front();
                chk(s_axi_rdata, nxt[31:0]);
                chk(32'(s_axi_rresp), 32'(nxt[33:32]));
            end
        end
    end
    initial begin
        resetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        void'($urandom(83));
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h1C, 32'h0);
        wr(8'h08, 32'h0A05);
        $display("test reset ended");
        cs(8'h25, 8'h14);
        cs(8'h45, 8'h0A);
        cs(8'h25, 8'h14);
        cs(8'h3F, 8'h00);
        cs(8'h45, 8'h0A);
        cs(8'h46, 8'h00);
        $display("test addressing ended");
        ctl.lvl(1'b0, 1'b1);
        rd(8'h00, 32'h02);
        ctl.lvl(1'b0, 1'b0);
        wr(8'h04, 32'h4);
        rd(8'h00, 32'h04);
        wr(8'h04, 32'h0);
        wr(8'h0C, 32'h4);
        rd(8'h00, 32'h00);
        wr(8'h04, 32'h8);
        rd(8'h00, 32'h02);
        wr(8'h04, 32'h0);
        wr(8'h0C, 32'h8);
        rd(8'h00, 32'h00);
        ctl.lvl(1'b1, 1'b0);
        cs(8'h25, 8'h14);
        wr(8'h0C, 32'h2);
        rd(8'h00, 32'h10);
        ctl.lvl(1'b0, 1'b0);
        $display("test local ended");
        cs(8'h45, 8'h0A);
        ctl.clr();
        rd(8'h00, 32'h08);
        cs(8'h25, 8'h14);
        ctl.clr();
        rd(8'h00, 32'h10);
        wr(8'h0C, 32'h1);
        rd(8'h00, 32'h00);
        wr(8'h04, 32'h2);
        cs(8'h2A, 8'h15);
        wr(8'h04, 32'h0);
        rd(8'h00, 32'h14);
        wr(8'h04, 32'h2);
        cs(8'h25, 8'h14);
        cs(8'h2A, 8'h15);
        wr(8'h0C, 32'h1);
        rd(8'h00, 32'h00);
        wr(8'h04, 32'h0);
        $display("test clears ended");
        wr(8'h18, 32'h3);
        wr(8'h14, 32'h1);
        rd(8'h10, 32'h0);
        cs(8'h25, 8'h14);
        chk(32'(irq), 32'h1);
        rd(8'h10, 32'h1);
        wr(8'h14, 32'h0);
        @(negedge sys_clk);
        chk(32'(irq), 32'h0);
        wr(8'h18, 32'h3);
        rd(8'h10, 32'h0);
        $display("test irq ended");
        repeat (4) begin
            b = 8'(($urandom % 31) + 1);
            if (b <= 8'h05) b = b - 8'h01;
            cs(8'h45, 8'h0A);
            cs(8'h40 | b, 8'h00);
        end
        $display("test random ended");
        wr(8'h04, 32'h3);
        cs(8'h2A, 8'h15);
        wr(8'h04, 32'h1);
        rd(8'h00, 32'h14);
        wr(8'h0C, 32'h2);
        rd(8'h00, 32'h14);
        s_axi_wstrb <= 4'h1;
        wr(8'h08, 32'h0B06);
        s_axi_wstrb <= 4'hF;
        rd(8'h08, 32'h0A06);
        wr(8'h1C, 32'h1);
        $display("test modes ended");
        repeat (3) @(posedge sys_clk);
        tally_and_finish();
    end
endmodule
